/* File: logic/pbdim_channel.sv */
// pbdim_channel: one push-button dimming channel with double-click object and block handling
// assumes a debounced button level synchronous to mclk_in and a telegram sink that never stalls
//
// Operation
// - delayed switch-on: send dimmer on 5, 10 or 15 s after restoration.
// - delayed switch-off: send dimmer off 5, 10 or 15 s after restoration.
// - ignore-block option keeps that telegram working whatever the block state.
// - entering block sends nothing, dimmer on or dimmer off per setting.
// - leaving block sends nothing, dimmer on or dimmer off per setting.
// - double-click object has one of six selectable data types.
// - switching type sends on, off or inverse of held state.
// - priority type sends 00 inactive, 11 on, 10 off.
// - unsigned byte type sends configured constant 0 to 255.
// - percentage type sends configured byte 0 to 100 percent.
// - 2-byte float type sends configured value within plus or minus 670760.
// - 4-byte float type sends configured value within plus or minus 1E+38.
// - double-click telegram not repeated or resent every 1 to 60 minutes.
// - after bus restoration double-click value sent never, now, or 5/10/15 s later.
// - block set or cancel sends nothing or the double-click telegram.
// - block polarity selectable: 1 blocks by default, or 0 blocks.
// - double-click needs second press within 300 ms to 1 s window.
// - press held at least 300 ms to 1 s threshold is long.
`timescale 1ns/1ps
module pbdim_channel (
	input wire logic mclk_in, // 125 MHz clock
	input wire logic rst_in, // synchronous reset, active high
	input wire logic [3:0] addr_in, // register index
	input wire logic [31:0] wdata_in, // write data
	input wire logic wr_in, // write strobe
	input wire logic rd_in, // read strobe
	output logic [31:0] rdata_out, // read data, cycle after rd_in
	input wire logic button_in, // debounced button level, 1 = pressed
	input wire logic block_obj_in, // block object value from the bus
	input wire logic restore_in, // one-cycle pulse: bus and mains returned
	input wire logic dimmer_state_in, // held switching state of the actuator
	output logic tg_valid_out, // one-cycle telegram pulse
	output logic [1:0] tg_kind_out, // telegram kind
	output logic [2:0] tg_type_out, // double-click data type
	output logic [31:0] tg_data_out, // telegram payload
	output logic short_press_out, // one-cycle pulse: short press
	output logic long_press_out, // one-cycle pulse: long press reached
	output logic blocked_out // channel blocked
);
	typedef struct packed {
		logic [31:0] cfg;
		logic [31:0] dc_val;
		logic [5:0] cyc;
		logic [31:0] rdata;
		logic [16:0] tick_cnt;
		logic [9:0] ms_cnt;
		logic [5:0] sec_cnt;
		logic [10:0] press_ms;
		logic [10:0] gap_ms;
		pbdim_pkg::pbdim_st_t st;
		logic long_seen;
		logic blocked;
		logic [4:0] rest_dly;
		logic rest_on;
		logic rest_pend;
		logic [4:0] dc_dly;
		logic dc_pend;
		logic cyc_run;
		logic [5:0] cyc_min;
		logic tg_valid;
		logic [1:0] tg_kind;
		logic [2:0] tg_type;
		logic [31:0] tg_data;
		logic short_p;
		logic long_p;
		logic [7:0] errs;
	} pbdim_state_t;

	pbdim_state_t s_r, s_nxt;

	// threshold of 300 ms plus 100 ms per step, used for long press and double-click window
	function automatic logic [10:0] pbdim_thr(input logic [2:0] sel);
		pbdim_thr = 11'(pbdim_pkg::BASE_MS) + 11'(pbdim_pkg::STEP_MS) * {8'h00, sel};
	endfunction

	// delay in seconds for a restoration setting, zero for immediate
	function automatic logic [4:0] pbdim_rdly(input logic [2:0] rs, input logic off15);
		case (rs)
			pbdim_pkg::PBDIM_RS_ON5, pbdim_pkg::PBDIM_RS_OFF5: pbdim_rdly = pbdim_pkg::DLY_5S;
			pbdim_pkg::PBDIM_RS_ON10: pbdim_rdly = pbdim_pkg::DLY_10S;
			pbdim_pkg::PBDIM_RS_ON15: pbdim_rdly = pbdim_pkg::DLY_15S;
			pbdim_pkg::PBDIM_RS_OFF10: pbdim_rdly = off15 ? pbdim_pkg::DLY_15S : pbdim_pkg::DLY_10S;
			default: pbdim_rdly = 5'd0;
		endcase
	endfunction

	// double-click payload per data type
	function automatic logic [31:0] pbdim_dcdata(input logic [31:0] cfg, input logic [31:0] v,
		input logic held);
		logic [1:0] sw;
		sw = cfg[pbdim_pkg::CFG_DC_SW_LSB +: 2];
		case (cfg[pbdim_pkg::CFG_DC_TYPE_LSB +: 3])
			pbdim_pkg::PBDIM_DT_SW:
				pbdim_dcdata = {31'h0, (sw == pbdim_pkg::SW_TOGGLE) ? ~held : (sw == pbdim_pkg::SW_ON)};
			pbdim_pkg::PBDIM_DT_PRIO:
				pbdim_dcdata = {30'h0, cfg[pbdim_pkg::CFG_DC_PRIO_LSB +: 2]};
			pbdim_pkg::PBDIM_DT_U8, pbdim_pkg::PBDIM_DT_PCT:
				pbdim_dcdata = {24'h0, v[7:0]};
			pbdim_pkg::PBDIM_DT_F16:
				pbdim_dcdata = {16'h0, v[15:0]};
			default:
				pbdim_dcdata = v;
		endcase
	endfunction

	logic blk_raw;
	logic tick_ms, tick_s, tick_min;
	logic press_rise, press_fall;
	logic dc_event, block_set, block_clr;
	logic dc_ign, dim_ign;
	logic [2:0] rsel;

	// time base enables; the divider runs free so delays end up to one tick early
	assign tick_ms = (s_r.tick_cnt == 17'(pbdim_pkg::TICK_CYC - 1));
	assign tick_s = tick_ms && (s_r.ms_cnt == 10'(pbdim_pkg::SEC_MS - 1));
	assign tick_min = tick_s && (s_r.sec_cnt == 6'(pbdim_pkg::MIN_SEC - 1));
	assign rsel = s_r.cfg[pbdim_pkg::CFG_RESTORE_LSB +: 3];
	// polarity of the block object and enable of the block function
	assign blk_raw = s_r.cfg[pbdim_pkg::CFG_BLOCK_EN]
		&& (block_obj_in ^ s_r.cfg[pbdim_pkg::CFG_BLOCK_POL]);
	assign block_set = blk_raw && !s_r.blocked;
	assign block_clr = !blk_raw && s_r.blocked;
	assign dim_ign = (s_r.cfg[pbdim_pkg::CFG_BSET_LSB +: 2] == pbdim_pkg::PBDIM_BR_IGNORE);
	assign dc_ign = (s_r.cfg[pbdim_pkg::CFG_DC_BSET_LSB +: 2] == pbdim_pkg::PBDIM_BR_IGNORE);
	assign press_rise = button_in && (s_r.st == pbdim_pkg::PBDIM_IDLE || s_r.st == pbdim_pkg::PBDIM_WAIT2);
	assign press_fall = !button_in && (s_r.st == pbdim_pkg::PBDIM_PRESS || s_r.st == pbdim_pkg::PBDIM_PRESS2);
	// second press inside the window counts as double-click; blocked channel drops it unless ignored
	assign dc_event = press_rise && s_r.st == pbdim_pkg::PBDIM_WAIT2
		&& s_r.cfg[pbdim_pkg::CFG_DC_EN] && (!s_r.blocked || dc_ign);

	always_comb begin
		s_nxt = s_r;
		s_nxt.tg_valid = 1'b0;
		s_nxt.short_p = 1'b0;
		s_nxt.long_p = 1'b0;
		s_nxt.rdata = 32'h0;
		// time base
		s_nxt.tick_cnt = tick_ms ? 17'h0 : s_r.tick_cnt + 17'h1;
		if (tick_ms) begin
			s_nxt.ms_cnt = tick_s ? 10'h0 : s_r.ms_cnt + 10'h1;
		end
		if (tick_s) begin
			s_nxt.sec_cnt = tick_min ? 6'h0 : s_r.sec_cnt + 6'h1;
		end
		// press classifier
		if (tick_ms && s_r.press_ms != 11'h7ff) begin
			s_nxt.press_ms = s_r.press_ms + 11'h1;
		end
		if (tick_ms && s_r.gap_ms != 11'h7ff) begin
			s_nxt.gap_ms = s_r.gap_ms + 11'h1;
		end
		case (s_r.st)
			pbdim_pkg::PBDIM_IDLE, pbdim_pkg::PBDIM_WAIT2: begin
				if (button_in) begin
					s_nxt.st = (s_r.st == pbdim_pkg::PBDIM_WAIT2) ? pbdim_pkg::PBDIM_PRESS2 : pbdim_pkg::PBDIM_PRESS;
					s_nxt.press_ms = 11'h0;
					s_nxt.long_seen = 1'b0;
				end else if (s_r.st == pbdim_pkg::PBDIM_WAIT2
					&& s_r.gap_ms >= pbdim_thr(s_r.cfg[pbdim_pkg::CFG_DCWIN_LSB +: 3])) begin
					s_nxt.st = pbdim_pkg::PBDIM_IDLE;
				end
			end
			pbdim_pkg::PBDIM_PRESS, pbdim_pkg::PBDIM_PRESS2: begin
				if (!s_r.long_seen && s_r.press_ms >= pbdim_thr(s_r.cfg[pbdim_pkg::CFG_LONG_LSB +: 3])) begin
					s_nxt.long_seen = 1'b1;
					s_nxt.long_p = 1'b1;
				end
				if (press_fall) begin
					s_nxt.short_p = !s_r.long_seen;
					s_nxt.gap_ms = 11'h0;
					s_nxt.st = (s_r.st == pbdim_pkg::PBDIM_PRESS && !s_r.long_seen) ? pbdim_pkg::PBDIM_WAIT2
						: pbdim_pkg::PBDIM_IDLE;
				end
			end
			default: s_nxt.st = pbdim_pkg::PBDIM_IDLE;
		endcase
		// block state tracking
		s_nxt.blocked = blk_raw;
		// restoration delays count in whole seconds
		if (tick_s && s_r.rest_dly != 5'h0) begin
			s_nxt.rest_dly = s_r.rest_dly - 5'h1;
		end
		if (tick_s && s_r.dc_dly != 5'h0) begin
			s_nxt.dc_dly = s_r.dc_dly - 5'h1;
		end
		if (tick_min && s_r.cyc_run) begin
			s_nxt.cyc_min = (s_r.cyc_min <= 6'h1) ? s_r.cyc : s_r.cyc_min - 6'h1;
		end
		// telegram sources, lowest priority first so later ones win the single output slot
		if (s_r.dc_pend && s_r.dc_dly == 5'h0) begin
			s_nxt.dc_pend = 1'b0;
			s_nxt.tg_valid = 1'b1;
			s_nxt.tg_kind = pbdim_pkg::TG_DCLICK;
		end
		if (tick_min && s_r.cyc_run && s_r.cyc_min <= 6'h1 && (!s_r.blocked || dc_ign)) begin
			s_nxt.tg_valid = 1'b1;
			s_nxt.tg_kind = pbdim_pkg::TG_DCLICK;
		end
		if (dc_event) begin
			s_nxt.tg_valid = 1'b1;
			s_nxt.tg_kind = pbdim_pkg::TG_DCLICK;
			s_nxt.cyc_run = (s_r.cyc != 6'h0);
			s_nxt.cyc_min = s_r.cyc;
		end
		if (s_r.rest_pend && s_r.rest_dly == 5'h0) begin
			s_nxt.rest_pend = 1'b0;
			s_nxt.tg_valid = 1'b1;
			s_nxt.tg_kind = s_r.rest_on ? pbdim_pkg::TG_DIM_ON : pbdim_pkg::TG_DIM_OFF;
		end
		if (block_set) begin
			if (!dim_ign) begin
				s_nxt.rest_pend = 1'b0;
			end
			if (!dc_ign) begin
				s_nxt.cyc_run = 1'b0;
			end
			if (s_r.cfg[pbdim_pkg::CFG_DC_EN]
				&& s_r.cfg[pbdim_pkg::CFG_DC_BSET_LSB +: 2] == pbdim_pkg::PBDIM_BR_ON) begin
				s_nxt.tg_valid = 1'b1;
				s_nxt.tg_kind = pbdim_pkg::TG_DCLICK;
			end
			if (s_r.cfg[pbdim_pkg::CFG_BSET_LSB +: 2] == pbdim_pkg::PBDIM_BR_ON
				|| s_r.cfg[pbdim_pkg::CFG_BSET_LSB +: 2] == pbdim_pkg::PBDIM_BR_OFF) begin
				s_nxt.tg_valid = 1'b1;
				s_nxt.tg_kind = (s_r.cfg[pbdim_pkg::CFG_BSET_LSB +: 2] == pbdim_pkg::PBDIM_BR_ON)
					? pbdim_pkg::TG_DIM_ON : pbdim_pkg::TG_DIM_OFF;
			end
		end
		if (block_clr) begin
			if (s_r.cfg[pbdim_pkg::CFG_DC_EN] && s_r.cfg[pbdim_pkg::CFG_DC_BCLR_LSB]) begin
				s_nxt.tg_valid = 1'b1;
				s_nxt.tg_kind = pbdim_pkg::TG_DCLICK;
			end
			if (s_r.cfg[pbdim_pkg::CFG_BCLR_LSB +: 2] == pbdim_pkg::PBDIM_BR_ON
				|| s_r.cfg[pbdim_pkg::CFG_BCLR_LSB +: 2] == pbdim_pkg::PBDIM_BR_OFF) begin
				s_nxt.tg_valid = 1'b1;
				s_nxt.tg_kind = (s_r.cfg[pbdim_pkg::CFG_BCLR_LSB +: 2] == pbdim_pkg::PBDIM_BR_ON)
					? pbdim_pkg::TG_DIM_ON : pbdim_pkg::TG_DIM_OFF;
			end
		end
		// type and payload move only with a telegram, so they stand until the next one
		if (s_nxt.tg_valid) begin
			s_nxt.tg_type = s_r.cfg[pbdim_pkg::CFG_DC_TYPE_LSB +: 3];
			s_nxt.tg_data = (s_nxt.tg_kind == pbdim_pkg::TG_DCLICK)
				? pbdim_dcdata(s_r.cfg, s_r.dc_val, dimmer_state_in) : 32'h0;
		end
		// bus and mains restoration starts both delayed responses
		if (restore_in || (wr_in && addr_in == pbdim_pkg::REG_CTRL && wdata_in[pbdim_pkg::CTRL_RESTORE])) begin
			s_nxt.rest_pend = (rsel != pbdim_pkg::PBDIM_RS_NONE) && (!blk_raw || dim_ign);
			s_nxt.rest_on = (rsel == pbdim_pkg::PBDIM_RS_ON) || (rsel == pbdim_pkg::PBDIM_RS_ON5)
				|| (rsel == pbdim_pkg::PBDIM_RS_ON10) || (rsel == pbdim_pkg::PBDIM_RS_ON15);
			s_nxt.rest_dly = pbdim_rdly(rsel, s_r.cfg[pbdim_pkg::CFG_OFF15]);
			s_nxt.dc_pend = s_r.cfg[pbdim_pkg::CFG_DC_EN]
				&& s_r.cfg[pbdim_pkg::CFG_DC_REST_LSB +: 3] != pbdim_pkg::DR_NONE;
			case (s_r.cfg[pbdim_pkg::CFG_DC_REST_LSB +: 3])
				pbdim_pkg::DR_5S: s_nxt.dc_dly = pbdim_pkg::DLY_5S;
				pbdim_pkg::DR_10S: s_nxt.dc_dly = pbdim_pkg::DLY_10S;
				pbdim_pkg::DR_15S: s_nxt.dc_dly = pbdim_pkg::DLY_15S;
				default: s_nxt.dc_dly = 5'h0;
			endcase
		end
		// register writes; out-of-range repetition times are refused and counted, other registers take any value
		if (wr_in) begin
			case (addr_in)
				pbdim_pkg::REG_CFG: s_nxt.cfg = wdata_in;
				pbdim_pkg::REG_DC_VAL: s_nxt.dc_val = wdata_in;
				pbdim_pkg::REG_CYC: begin
					if (wdata_in[5:0] <= pbdim_pkg::CYC_MAX && wdata_in[31:6] == 26'h0) begin
						s_nxt.cyc = wdata_in[5:0];
					end else begin
						s_nxt.errs = s_r.errs + 8'h1;
					end
				end
				default: ;
			endcase
		end
		// register reads, answered in the following cycle
		if (rd_in) begin
			case (addr_in)
				pbdim_pkg::REG_CFG: s_nxt.rdata = s_r.cfg;
				pbdim_pkg::REG_DC_VAL: s_nxt.rdata = s_r.dc_val;
				pbdim_pkg::REG_CYC: s_nxt.rdata = {26'h0, s_r.cyc};
				pbdim_pkg::REG_STAT: s_nxt.rdata = {s_r.errs, 12'h0, s_r.st, s_r.cyc_run, s_r.dc_pend,
					s_r.rest_pend, s_r.rest_dly, button_in, s_r.blocked};
				default: s_nxt.rdata = 32'h0;
			endcase
		end
	end

	// one register stage for the whole state
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			s_r <= '0;
			s_r.cfg <= pbdim_pkg::CFG_RST;
			s_r.cyc <= pbdim_pkg::CYC_RST;
			s_r.st <= pbdim_pkg::PBDIM_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdata_out = s_r.rdata;
	assign tg_valid_out = s_r.tg_valid;
	assign tg_kind_out = s_r.tg_kind;
	assign tg_type_out = s_r.tg_type;
	assign tg_data_out = s_r.tg_data;
	assign short_press_out = s_r.short_p;
	assign long_press_out = s_r.long_p;
	assign blocked_out = s_r.blocked;
endmodule

/* File: logic/pbdim_pkg.sv */
// pbdim_pkg: constants, encodings and register map of the push-button dimming channel
// assumes a 125 MHz system clock and a plain address/strobe register port
package pbdim_pkg;
	// clock and time base
	localparam int CLK_HZ = 125000000;
	localparam int MS_PER_TICK = 1;
	localparam int TICK_CYC = CLK_HZ / 1000 * MS_PER_TICK; // cycles per 1 ms tick
	localparam int SEC_MS = 1000;
	localparam int MIN_SEC = 60;
	// register port
	localparam int AW = 4;
	localparam int DW = 32;
	localparam logic [3:0] REG_CFG = 4'h0;
	localparam logic [3:0] REG_DC_VAL = 4'h1;
	localparam logic [3:0] REG_CYC = 4'h2;
	localparam logic [3:0] REG_STAT = 4'h3;
	localparam logic [3:0] REG_CTRL = 4'h4;
	// cfg register fields
	localparam int CFG_RESTORE_LSB = 0;  // 3 bits
	localparam int CFG_BSET_LSB = 3;     // 2 bits
	localparam int CFG_BCLR_LSB = 5;     // 2 bits
	localparam int CFG_BLOCK_EN = 7;
	localparam int CFG_BLOCK_POL = 8;    // 0: block with 1, 1: block with 0
	localparam int CFG_DC_EN = 9;
	localparam int CFG_DC_TYPE_LSB = 10; // 3 bits
	localparam int CFG_DC_SW_LSB = 13;   // 2 bits
	localparam int CFG_DC_PRIO_LSB = 15; // 2 bits
	localparam int CFG_DC_REST_LSB = 17; // 3 bits
	localparam int CFG_DC_BSET_LSB = 20; // 2 bits
	localparam int CFG_DC_BCLR_LSB = 22; // 1 bit
	localparam int CFG_LONG_LSB = 23;    // 3 bits, 300 ms + 100 ms * n
	localparam int CFG_DCWIN_LSB = 26;   // 3 bits, 300 ms + 100 ms * n
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam logic [5:0] CYC_RST = 6'h00; // 0: no repetition, n: every n minutes
	localparam logic [5:0] CYC_MAX = 6'h3c;
	localparam int BASE_MS = 300;
	localparam int STEP_MS = 100;
	localparam logic [31:0] F16_MAX = 32'd670760; // range limit of the 2-byte float value
	// ctrl register bits
	localparam int CTRL_RESTORE = 0;
	// restoration responses
	typedef enum logic [2:0] {
		PBDIM_RS_NONE = 3'h0, PBDIM_RS_ON = 3'h1, PBDIM_RS_OFF = 3'h2,
		PBDIM_RS_ON5 = 3'h3, PBDIM_RS_ON10 = 3'h4, PBDIM_RS_ON15 = 3'h5,
		PBDIM_RS_OFF5 = 3'h6, PBDIM_RS_OFF10 = 3'h7
	} pbdim_rest_t;
	localparam logic [2:0] RS_OFF15_ALT = 3'h7; // off after 15 s selected via cfg bit 30
	localparam int CFG_OFF15 = 30;
	// block responses
	typedef enum logic [1:0] {
		PBDIM_BR_IGNORE = 2'h0, PBDIM_BR_NONE = 2'h1, PBDIM_BR_ON = 2'h2, PBDIM_BR_OFF = 2'h3
	} pbdim_bresp_t;
	// double-click types
	typedef enum logic [2:0] {
		PBDIM_DT_SW = 3'h0, PBDIM_DT_PRIO = 3'h1, PBDIM_DT_U8 = 3'h2,
		PBDIM_DT_PCT = 3'h3, PBDIM_DT_F16 = 3'h4, PBDIM_DT_F32 = 3'h5
	} pbdim_dtype_t;
	localparam logic [1:0] SW_ON = 2'h0;
	localparam logic [1:0] SW_OFF = 2'h1;
	localparam logic [1:0] SW_TOGGLE = 2'h2;
	localparam logic [1:0] PRIO_INACT = 2'h0;
	localparam logic [1:0] PRIO_ON = 2'h3;
	localparam logic [1:0] PRIO_OFF = 2'h2;
	// double-click restoration responses
	localparam logic [2:0] DR_NONE = 3'h0;
	localparam logic [2:0] DR_NOW = 3'h1;
	localparam logic [2:0] DR_5S = 3'h2;
	localparam logic [2:0] DR_10S = 3'h3;
	localparam logic [2:0] DR_15S = 3'h4;
	localparam logic [4:0] DLY_5S = 5'd5;
	localparam logic [4:0] DLY_10S = 5'd10;
	localparam logic [4:0] DLY_15S = 5'd15;
	// telegram kinds on the output port
	localparam logic [1:0] TG_DIM_ON = 2'h0;
	localparam logic [1:0] TG_DIM_OFF = 2'h1;
	localparam logic [1:0] TG_DCLICK = 2'h2;
	// press classifier states
	typedef enum logic [1:0] {
		PBDIM_IDLE = 2'b00, PBDIM_PRESS = 2'b01, PBDIM_WAIT2 = 2'b11, PBDIM_PRESS2 = 2'b10
	} pbdim_st_t;
endpackage

/* File: test/pbdim_actuator_model.sv */
// pbdim_actuator_model: dimming actuator at the far end of the telegram port
// assumes one-cycle telegram pulses on the bench clock; it never refuses one
`timescale 1ns/1ps
module pbdim_actuator_model (
	input wire logic clk_in, // bench clock
	input wire logic rst_in, // sync reset
	input wire logic tg_valid_in, // telegram pulse
	input wire logic [1:0] tg_kind_in, // telegram kind
	input wire logic [2:0] tg_type_in, // data type
	input wire logic [31:0] tg_data_in, // payload
	output logic dimmer_state_out, // held switching state
	output int rx_count_out, // telegrams taken
	output logic [1:0] rx_kind_out, // last kind
	output logic [31:0] rx_data_out // last payload
);
	// takes every telegram at once; only switching values move the held state
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			dimmer_state_out <= 1'b0;
			rx_count_out <= 0;
			rx_kind_out <= 2'h0;
			rx_data_out <= 32'h0;
		end else if (tg_valid_in) begin
			rx_count_out <= rx_count_out + 1;
			rx_kind_out <= tg_kind_in;
			rx_data_out <= tg_data_in;
			if (tg_kind_in != pbdim_pkg::TG_DCLICK)
				dimmer_state_out <= (tg_kind_in == pbdim_pkg::TG_DIM_ON);
			else if (tg_type_in == pbdim_pkg::PBDIM_DT_SW)
				dimmer_state_out <= tg_data_in[0]; // state a later toggle inverts
		end
	end
endmodule

/* File: test/pbdim_channel_props.sv */
// pbdim_channel_props: port-level checks of the dimming channel
// assumes it is bound to pbdim_channel and sees only that module's ports
`timescale 1ns/1ps
module pbdim_channel_props (
	input wire logic mclk_in, // clock
	input wire logic rst_in, // sync reset
	input wire logic [3:0] addr_in, // register index
	input wire logic [31:0] wdata_in, // write data
	input wire logic wr_in, // write strobe
	input wire logic rd_in, // read strobe
	input wire logic [31:0] rdata_out, // read data
	input wire logic block_obj_in, // block object
	input wire logic restore_in, // restoration pulse
	input wire logic tg_valid_out, // telegram pulse
	input wire logic [1:0] tg_kind_out, // telegram kind
	input wire logic [2:0] tg_type_out, // data type
	input wire logic [31:0] tg_data_out, // payload
	input wire logic blocked_out // blocked level
);
	logic [31:0] cfg_r; // shadow of the config register
	logic [31:0] val_r; // shadow of the double-click value
	logic blk_lvl; // object at its blocking level
	logic dc_tg; // double-click telegram
	logic on_tg; // dimmer on telegram
	logic off_tg; // dimmer off telegram
	// shadows follow software writes, since the body is out of sight
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			cfg_r <= pbdim_pkg::CFG_RST;
			val_r <= 32'h0;
		end else if (wr_in && addr_in == pbdim_pkg::REG_CFG) begin
			cfg_r <= wdata_in;
		end else if (wr_in && addr_in == pbdim_pkg::REG_DC_VAL) begin
			val_r <= wdata_in;
		end
	end
	// polarity bit turns the meaning of the object round
	assign blk_lvl = cfg_r[7] && (block_obj_in != cfg_r[8]);
	assign dc_tg = tg_valid_out && tg_kind_out == pbdim_pkg::TG_DCLICK;
	assign on_tg = tg_valid_out && tg_kind_out == pbdim_pkg::TG_DIM_ON;
	assign off_tg = tg_valid_out && tg_kind_out == pbdim_pkg::TG_DIM_OFF;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	property p_rd_idle; !$past(rd_in) |-> rdata_out == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside a read");
	property p_block; blk_lvl [*3] |-> blocked_out; endproperty
	a_block: assert property (p_block) else $error("block level not followed");
	property p_dc_type; dc_tg |-> tg_type_out == cfg_r[12:10]; endproperty
	a_dc_type: assert property (p_dc_type) else $error("wrong data type");
	property p_prio; dc_tg && tg_type_out == pbdim_pkg::PBDIM_DT_PRIO |-> tg_data_out[1:0] == cfg_r[16:15]; endproperty
	a_prio: assert property (p_prio) else $error("wrong priority code");
	property p_byte; dc_tg && tg_type_out inside {pbdim_pkg::PBDIM_DT_U8, pbdim_pkg::PBDIM_DT_PCT}
		|-> tg_data_out[7:0] == val_r[7:0]; endproperty
	a_byte: assert property (p_byte) else $error("wrong byte value");
	property p_rest_on; restore_in && cfg_r[2:0] == pbdim_pkg::PBDIM_RS_ON && !blocked_out |-> ##[1:3] on_tg; endproperty
	a_rest_on: assert property (p_rest_on) else $error("no on after restoration");
	property p_set_on; $rose(blk_lvl) && $stable(cfg_r) && cfg_r[4:3] == pbdim_pkg::PBDIM_BR_ON |-> ##[1:3] on_tg;
	endproperty
	a_set_on: assert property (p_set_on) else $error("no on at block set");
	property p_clr_off; $fell(blk_lvl) && $stable(cfg_r) && cfg_r[6:5] == pbdim_pkg::PBDIM_BR_OFF |-> ##[1:3] off_tg;
	endproperty
	a_clr_off: assert property (p_clr_off) else $error("no off at block cancel");
	c_block: cover property ($rose(blocked_out));
	c_f32: cover property (dc_tg && tg_type_out == pbdim_pkg::PBDIM_DT_F32);
	c_rest: cover property (restore_in ##[1:3] on_tg);
endmodule
bind pbdim_channel pbdim_channel_props pbdim_channel_props_inst (.mclk_in, .rst_in, .addr_in, .wdata_in, .wr_in,
	.rd_in, .rdata_out, .block_obj_in, .restore_in, .tg_valid_out, .tg_kind_out, .tg_type_out, .tg_data_out,
	.blocked_out);

/* File: test/pbdim_channel_tb.sv */
// pbdim_channel_tb: self-checking bench of the dimming channel
// assumes the actuator model and the bound checker; long timers are left alone
`timescale 1ns/1ps
module pbdim_channel_tb;
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [3:0] addr_in = 4'h0;
	logic [31:0] wdata_in = 32'h0;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic block_obj_in = 1'b0;
	logic restore_in = 1'b0;
	logic button_in = 1'b0;
	logic short_press, long_press;
	logic dimmer_state_in, tg_valid_out, blocked_out;
	logic [1:0] tg_kind_out, rx_kind, pr;
	logic [2:0] tg_type_out, dt;
	logic [31:0] rdata_out, tg_data_out, rx_data, d, v, e;
	int rx_count, seed;
	int seen = 0;
	int fail_count = 0;
	int n_tests = 0;
	// 125 MHz clock
	always #4 mclk_in = ~mclk_in;
	pbdim_channel pbdim_channel_inst (.mclk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
		.button_in, .block_obj_in, .restore_in, .dimmer_state_in, .tg_valid_out, .tg_kind_out,
		.tg_type_out, .tg_data_out, .short_press_out(short_press), .long_press_out(long_press), .blocked_out);
	pbdim_actuator_model pbdim_actuator_model_inst (.clk_in(mclk_in), .rst_in, .tg_valid_in(tg_valid_out),
		.tg_kind_in(tg_kind_out), .tg_type_in(tg_type_out), .tg_data_in(tg_data_out),
		.dimmer_state_out(dimmer_state_in), .rx_count_out(rx_count), .rx_kind_out(rx_kind), .rx_data_out(rx_data));
	// every comparison passes through here
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// one-cycle strobes, launched just after an edge
	task automatic wr(input logic [3:0] a, input logic [31:0] w);
		@(posedge mclk_in);
		addr_in <= a;
		wdata_in <= w;
		wr_in <= 1'b1;
		@(posedge mclk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] r);
		@(posedge mclk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		#1 r = rdata_out;
	endtask
	// bus side: block object level and a restoration pulse
	task automatic drive(input logic obj, input logic rp);
		@(posedge mclk_in);
		block_obj_in <= obj;
		restore_in <= rp;
		@(posedge mclk_in);
		restore_in <= 1'b0;
	endtask
	// bounded wait for the actuator; k < 0 means nothing may arrive
	task automatic exp_tg(input int k, input logic [31:0] dat);
		int n;
		n = 0;
		while (rx_count == seen && n < 12) begin
			@(posedge mclk_in);
			#1 n++;
		end
		chk(32'(rx_count - seen), (k < 0) ? 32'h0 : 32'h1);
		if (k >= 0) begin
			chk({30'h0, rx_kind}, 32'(k));
			chk(rx_data, dat);
		end
		seen = rx_count;
	endtask
	// config word with block and double-click enabled (bits 7 and 9)
	function automatic logic [31:0] mk(input int rs, bs, bc, pol, t, sw, p, dr, dbs, dbc);
		mk = 32'(rs) | 32'(bs) << 3 | 32'(bc) << 5 | 32'h280 | 32'(pol) << 8 | 32'(t) << 10 | 32'(sw) << 13
			| 32'(p) << 15 | 32'(dr) << 17 | 32'(dbs) << 20 | 32'(dbc) << 22;
	endfunction
	// reference value of a double-click telegram
	function automatic logic [31:0] dc_exp(input logic [2:0] t, input int sw, input logic [1:0] p,
		input logic [31:0] val, input logic st);
		case (t)
			pbdim_pkg::PBDIM_DT_SW: dc_exp = (sw == 2) ? {31'h0, ~st} : {31'h0, sw == 0};
			pbdim_pkg::PBDIM_DT_PRIO: dc_exp = {30'h0, p};
			pbdim_pkg::PBDIM_DT_F16: dc_exp = {16'h0, val[15:0]};
			pbdim_pkg::PBDIM_DT_F32: dc_exp = val;
			default: dc_exp = {24'h0, val[7:0]};
		endcase
	endfunction
	// main sequence
	initial begin
		seed = $urandom(31);
		repeat (2) @(posedge mclk_in);
		rst_in <= 1'b0;
		rd(pbdim_pkg::REG_CFG, d);
		chk(d, pbdim_pkg::CFG_RST);
		rd(4'hf, d);
		chk(d, 32'h0);
		v = $urandom_range(60);
		wr(pbdim_pkg::REG_CYC, v);
		rd(pbdim_pkg::REG_CYC, d);
		chk(d, v);
		wr(pbdim_pkg::REG_CYC, 32'd61);
		rd(pbdim_pkg::REG_CYC, d);
		chk(d, v);
		rd(pbdim_pkg::REG_STAT, d);
		chk({24'h0, d[31:24]}, 32'h1);
		// immediate on and off, by pin and by control register
		for (int i = 0; i < 4; i++) begin
			wr(pbdim_pkg::REG_CFG, mk(1 + i % 2, 1, 1, 0, 0, 0, 0, 0, 0, 0));
			if (i < 2)
				drive(1'b0, 1'b1);
			else
				wr(pbdim_pkg::REG_CTRL, 32'h1);
			exp_tg(i % 2, 32'h0);
		end
		// short press, then a second press well inside the window: a double-click sending on
		@(posedge mclk_in);
		button_in <= 1'b1;
		@(posedge mclk_in);
		button_in <= 1'b0;
		@(posedge mclk_in);
		button_in <= 1'b1;
		#1 chk(short_press, 1'b1);
		chk(long_press, 1'b0);
		@(posedge mclk_in);
		button_in <= 1'b0;
		exp_tg(2, 32'h1);
		// the none, on and off set and cancel responses under both polarities
		for (int p = 0; p < 2; p++) begin
			for (int s = 1; s < 4; s++) begin
				for (int c = 1; c < 4; c++) begin
					wr(pbdim_pkg::REG_CFG, 32'h0);
					drive(p[0], 1'b0);
					wr(pbdim_pkg::REG_CFG, mk(0, s, c, p, 0, 0, 0, 0, 0, 0));
					drive(!p[0], 1'b0);
					exp_tg(s - 2, 32'h0);
					chk(blocked_out, 1'b1);
					drive(p[0], 1'b0);
					exp_tg(c - 2, 32'h0);
					chk(blocked_out, 1'b0);
				end
			end
		end
		// each double-click type and code, sent at block set and maybe at cancel
		for (int c = 0; c < 10; c++) begin
			dt = (c < 3) ? 3'h0 : (c < 6) ? 3'h1 : 3'(c - 4);
			pr = (c == 3) ? pbdim_pkg::PRIO_INACT : (c == 4) ? pbdim_pkg::PRIO_ON : pbdim_pkg::PRIO_OFF;
			v = (c == 7) ? $urandom_range(100) : $urandom;
			wr(pbdim_pkg::REG_CFG, 32'h0);
			wr(pbdim_pkg::REG_DC_VAL, v);
			wr(pbdim_pkg::REG_CFG, mk(0, 1, 1, 0, dt, c % 3, pr, 0, 2, c % 2));
			e = dc_exp(dt, c % 3, pr, v, dimmer_state_in);
			drive(1'b1, 1'b0);
			exp_tg(2, e);
			e = dc_exp(dt, c % 3, pr, v, dimmer_state_in);
			drive(1'b0, 1'b0);
			exp_tg((c % 2) ? 2 : -1, e);
		end
		// restoration sends the double-click value, then an ignored block
		wr(pbdim_pkg::REG_CFG, mk(0, 0, 0, 0, 2, 0, 0, 1, 0, 0));
		drive(1'b0, 1'b1);
		exp_tg(2, {24'h0, v[7:0]});
		wr(pbdim_pkg::REG_CFG, mk(1, 0, 1, 0, 0, 0, 0, 0, 0, 0));
		drive(1'b1, 1'b0);
		exp_tg(-1, 32'h0);
		drive(1'b1, 1'b1);
		exp_tg(0, 32'h0);
		// a pending delayed restoration dropped by a block
		drive(1'b0, 1'b0);
		wr(pbdim_pkg::REG_CFG, mk(3, 1, 1, 0, 0, 0, 0, 0, 0, 0));
		drive(1'b0, 1'b1);
		rd(pbdim_pkg::REG_STAT, d);
		chk({31'h0, d[7]}, 32'h1);
		drive(1'b1, 1'b0);
		rd(pbdim_pkg::REG_STAT, d);
		chk({31'h0, d[7]}, 32'h0);
		exp_tg(-1, 32'h0);
		final_report();
	end
	// hang guard: the sequence needs under 5000 cycles
	initial begin
		#200000;
		fail_count++;
		final_report();
	end
endmodule
